// ### hdl/trb_pkg.sv
// Package holding constants and carrier types for the reload timer
package trb_pkg;
  localparam int CNT_W = 16;
  localparam int PRE_W = 8;
  localparam int BAUD_DIV = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
  localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;

  typedef enum logic [1:0] {
    MODE_STD = 2'b00,
    MODE_CLR_TOP = 2'b01,
    MODE_DUAL_ONE = 2'b10,
    MODE_DUAL_TWO = 2'b11
  } trb_mode_type;

  // Software control bits
  typedef struct packed {
    logic runControl;
    logic downCountEnable;
    logic externalEnable;
    logic transmitClockSelect;
    logic receiveClockSelect;
    logic toggleOutputEnable;
    logic counterTimerSelect;
    trb_mode_type countModeSelect;
  } trb_ctrl_type;

  // Software clear strobes for the flags
  typedef struct packed {
    logic overflowClr;
    logic externalClr;
  } trb_clr_type;
endpackage

// ### hdl/trb_prescaler.sv
// Prescaler making the timer advance enable
`timescale 1ns/1ps
module trb_prescaler
  import trb_pkg::*;
#(
  parameter int WIDTH = PRE_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic [WIDTH-1:0] prescaleValue,
  // Tick
  output logic tick
);
  initial begin
    if (WIDTH < 1 || WIDTH > 16) $error("trb_prescaler: bad WIDTH");
  end

  logic [WIDTH-1:0] cnt_r;
  wire cntDone = (cnt_r >= prescaleValue);
  wire [WIDTH-1:0] cntInc = cnt_r + WIDTH'(1);

  // Stopped timer holds phase at zero so restart is a full period
  always_ff @(posedge clock) begin
    if (sys_rst || !run || cntDone) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cntInc;
    end
  end

  assign tick = run && cntDone;
endmodule

// ### hdl/trb_baud_div.sv
// Divide-by-sixteen of baud rollovers into serial bit clock
`timescale 1ns/1ps
module trb_baud_div
  import trb_pkg::*;
#(
  parameter int DIV = BAUD_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Rollover in, bit tick out
  input wire logic rollover,
  output logic bitTick
);
  localparam int DW = $clog2(DIV);
  initial begin
    if (DIV < 2 || (1 << DW) != DIV) $error("trb_baud_div: DIV must be power of two");
  end

  logic [DW-1:0] div_r;
  wire [DW-1:0] divInc = div_r + DW'(1);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_r <= '0;
    end else if (rollover) begin
      div_r <= divInc;
    end
  end

  assign bitTick = rollover && (div_r == DW'(DIV - 1));
endmodule

// ### hdl/trb_timer.sv
// Sixteen-bit auto-reload timer with baud and clock-out generation
`timescale 1ns/1ps
module trb_timer
  import trb_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Software control
  input wire trb_ctrl_type ctrl,
  input wire trb_clr_type flagClr,
  input wire logic [PRE_W-1:0] prescaleValue,
  input wire logic [7:0] reloadValueHigh,
  input wire logic [7:0] reloadValueLow,
  // External pins
  input wire logic externalTriggerInput,
  output logic togglePinOut,
  output logic togglePinOe,
  // Status
  output logic [7:0] countHighByte,
  output logic [7:0] countLowByte,
  output logic overflowFlag,
  output logic externalFlag,
  output logic interruptRequest,
  // Serial port bit clock
  output logic serialBitTick
);
  initial begin
    if (WIDTH != CNT_W) $error("trb_timer: WIDTH must equal CNT_W");
  end

  logic [CNT_W-1:0] count_r, count_nxt;
  logic [CNT_W-1:0] topBuf_r, topBuf_nxt;
  logic ovf_r, ovf_nxt;
  logic ext_r, ext_nxt;
  logic extIrqOk_r, extIrqOk_nxt;
  logic slopeDown_r, slopeDown_nxt;
  logic trigPrev_r;
  logic toggle_r, toggle_nxt;
  logic serialTick_r;
  logic irq_r;
  logic downCount_r;
  logic oe_r;

  wire tick;
  wire baudRoll;
  wire serialTickRaw;

  trb_prescaler #(.WIDTH(PRE_W)) uPre (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(ctrl.runControl),
    .prescaleValue(prescaleValue),
    .tick(tick)
  );

  trb_baud_div #(.DIV(BAUD_DIV)) uBaud (
    .clock(clock),
    .sys_rst(sys_rst),
    .rollover(baudRoll),
    .bitTick(serialTickRaw)
  );

  // Mode decode
  wire [CNT_W-1:0] reloadWord = {reloadValueHigh, reloadValueLow};
  wire isDual = ctrl.countModeSelect[1];
  wire isClrTop = (ctrl.countModeSelect == MODE_CLR_TOP);
  wire isStd = (ctrl.countModeSelect == MODE_STD);
  wire baudMode = ctrl.transmitClockSelect || ctrl.receiveClockSelect;
  wire clockOut = !ctrl.counterTimerSelect && ctrl.toggleOutputEnable;
  // Direction pin only steers when down-count and external enable are both on
  wire udMode = downCount_r && !isDual && !baudMode;
  wire countDown = udMode && ctrl.externalEnable && !externalTriggerInput;
  wire trigFall = ctrl.externalEnable && trigPrev_r && !externalTriggerInput;

  // Effective TOP in mode 01 and dual slope comes from the buffer
  wire [CNT_W-1:0] topVal = (isClrTop || isDual) ? topBuf_r : reloadWord;
  wire [CNT_W-1:0] countInc = count_r + CNT_ONE;
  wire [CNT_W-1:0] countDec = count_r - CNT_ONE;

  // Roll conditions
  wire upRollStd = (count_r == CNT_MAX);
  wire upRollTop = (count_r >= topVal);
  wire dnRollStd = (count_r == reloadWord);
  wire dnRollTop = (count_r == CNT_ZERO);
  wire upRoll = isStd || baudMode ? upRollStd : upRollTop;
  wire dnRoll = isStd ? dnRollStd : dnRollTop;
  wire dualTopHit = isDual && !slopeDown_r && upRollTop;
  wire dualZeroHit = isDual && slopeDown_r && (count_r == CNT_ONE || count_r == CNT_ZERO);
  wire singleRoll = !isDual && (countDown ? dnRoll : upRoll);
  wire anyRoll = tick && (singleRoll || dualZeroHit);

  assign baudRoll = tick && baudMode && upRollStd;

  always_comb begin
    count_nxt = count_r;
    topBuf_nxt = topBuf_r;
    ovf_nxt = ovf_r;
    ext_nxt = ext_r;
    extIrqOk_nxt = extIrqOk_r;
    slopeDown_nxt = slopeDown_r;
    toggle_nxt = toggle_r;
    // Software clears first, so a hardware event below wins in the same cycle
    if (flagClr.overflowClr) begin
      ovf_nxt = 1'b0;
    end
    if (flagClr.externalClr) begin
      ext_nxt = 1'b0;
      extIrqOk_nxt = 1'b0;
    end
    if (tick) begin
      if (baudMode) begin
        count_nxt = upRollStd ? reloadWord : countInc;
      end else if (isDual) begin
        if (!slopeDown_r) begin
          if (upRollTop) begin
            slopeDown_nxt = 1'b1;
            count_nxt = countDec;
          end else begin
            count_nxt = countInc;
          end
        end else if (count_r == CNT_ZERO || count_r == CNT_ONE) begin
          slopeDown_nxt = 1'b0;
          count_nxt = CNT_ZERO;
          topBuf_nxt = reloadWord;
        end else begin
          count_nxt = countDec;
        end
      end else if (countDown) begin
        if (dnRoll) begin
          count_nxt = isStd ? CNT_MAX : topVal;
          topBuf_nxt = reloadWord;
        end else begin
          count_nxt = countDec;
        end
      end else if (upRoll) begin
        count_nxt = isStd ? reloadWord : CNT_ZERO;
        topBuf_nxt = reloadWord;
      end else begin
        count_nxt = countInc;
      end
      if (!baudMode && (singleRoll || dualZeroHit || (dualTopHit &&
          ctrl.countModeSelect == MODE_DUAL_TWO))) begin
        ovf_nxt = 1'b1;
      end
      if (udMode && singleRoll) begin
        ext_nxt = !ext_r;
        extIrqOk_nxt = 1'b0;
      end
      if (clockOut && (singleRoll || dualZeroHit || baudRoll)) begin
        toggle_nxt = !toggle_r;
      end
    end
    if (!ctrl.runControl && !isDual) begin
      topBuf_nxt = (isClrTop) ? topBuf_r : reloadWord;
    end
    if (isDual) begin
      ext_nxt = slopeDown_nxt;
      extIrqOk_nxt = 1'b0;
    end
    if (trigFall && !udMode && !isDual) begin
      ext_nxt = 1'b1;
      extIrqOk_nxt = 1'b1;
      if (!baudMode) begin
        count_nxt = isStd ? reloadWord : CNT_ZERO;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_r <= CNT_ZERO;
      topBuf_r <= CNT_ZERO;
      ovf_r <= 1'b0;
      ext_r <= 1'b0;
      extIrqOk_r <= 1'b0;
      slopeDown_r <= 1'b0;
      trigPrev_r <= 1'b1;
      toggle_r <= 1'b0;
      serialTick_r <= 1'b0;
      irq_r <= 1'b0;
      // Timer comes out of reset counting up
      downCount_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      topBuf_r <= topBuf_nxt;
      ovf_r <= ovf_nxt;
      ext_r <= ext_nxt;
      extIrqOk_r <= extIrqOk_nxt;
      slopeDown_r <= slopeDown_nxt;
      trigPrev_r <= externalTriggerInput;
      toggle_r <= toggle_nxt;
      serialTick_r <= serialTickRaw;
      // Clock-out rollovers keep the flag but never interrupt
      irq_r <= (ovf_nxt && !clockOut) || extIrqOk_nxt;
      downCount_r <= ctrl.downCountEnable;
      oe_r <= clockOut;
    end
  end

  assign countHighByte = count_r[15:8];
  assign countLowByte = count_r[7:0];
  assign overflowFlag = ovf_r;
  assign externalFlag = ext_r;
  assign interruptRequest = irq_r;
  assign togglePinOut = toggle_r;
  assign togglePinOe = oe_r;
  assign serialBitTick = serialTick_r;
endmodule

// ### tb/trb_timer_chk.sv
// Port-level assertions for the reload timer
`timescale 1ns/1ps
module trb_timer_chk
  import trb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Observed ports
  input wire trb_ctrl_type ctrl,
  input wire logic [7:0] reloadValueHigh,
  input wire logic [7:0] reloadValueLow,
  input wire logic togglePinOut,
  input wire logic [7:0] countHighByte,
  input wire logic [7:0] countLowByte,
  input wire logic overflowFlag,
  input wire logic externalFlag,
  input wire logic interruptRequest,
  input wire logic serialBitTick
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic [15:0] cnt = {countHighByte, countLowByte};
  wire logic [15:0] rel = {reloadValueHigh, reloadValueLow};
  wire logic baud = ctrl.transmitClockSelect | ctrl.receiveClockSelect;
  wire logic upStd = ctrl.countModeSelect == MODE_STD && !ctrl.downCountEnable && !baud;
  wire logic dual = ctrl.countModeSelect[1] && !baud;
  wire logic clkOut = !ctrl.counterTimerSelect && ctrl.toggleOutputEnable;
  sequence s_atMax; upStd && cnt == CNT_MAX; endsequence
  sequence s_leftMax; cnt != CNT_MAX; endsequence
  property p_wrap; s_atMax ##1 s_leftMax |-> cnt == $past(rel) && overflowFlag; endproperty
  property p_irq; $rose(overflowFlag) && !$past(clkOut) |-> interruptRequest; endproperty
  // Only an interrupt-capable external flag may raise a request in clock-out
  property p_coQuiet; $past(clkOut) && !externalFlag |-> !interruptRequest; endproperty
  property p_baudQuiet; baud && $past(baud) |-> !$rose(overflowFlag); endproperty
  // External enable off too, so a stopped trigger reload of the count is not mistaken for a step
  property p_stop;
    !ctrl.runControl && !ctrl.externalEnable && $past(!ctrl.runControl) && $stable(rel)
      |-> $stable(cnt);
  endproperty
  property p_togWrap; upStd && $changed(togglePinOut) |-> cnt == rel; endproperty
  property p_bitGap; serialBitTick |=> !serialBitTick [*8]; endproperty
  property p_dualDown; dual && $past(dual) && cnt < $past(cnt) && cnt != CNT_ZERO |-> externalFlag;
  endproperty
  property p_dualZero;
    ctrl.countModeSelect == MODE_DUAL_ONE && !baud && $rose(overflowFlag) |-> cnt == CNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap reload wrong");
  a_irq: assert property (p_irq) else $error("flag without request");
  a_coQuiet: assert property (p_coQuiet) else $error("clock-out raised request");
  a_baudQuiet: assert property (p_baudQuiet) else $error("baud set flag");
  a_stop: assert property (p_stop) else $error("count moved while stopped");
  a_togWrap: assert property (p_togWrap) else $error("toggle off wrap");
  a_bitGap: assert property (p_bitGap) else $error("bit ticks too close");
  a_dualDown: assert property (p_dualDown) else $error("direction flag low");
  a_dualZero: assert property (p_dualZero) else $error("flag not at zero");
endmodule

// ### tb/trb_far_end.sv
// Far-side model: trigger pin, clock-out and bit clock timing
`timescale 1ns/1ps
module trb_far_end (
  // Clock
  input wire logic clock,
  // Pin level commanded by the bench
  input wire logic trigLevel,
  output logic externalTriggerInput,
  // Observed
  input wire logic togglePinOut,
  input wire logic togglePinOe,
  input wire logic serialBitTick,
  // Gaps in clocks between edges
  output int toggleGap,
  output int tickGap
);
  int cyc = 0;
  int lastTog = 0;
  int lastTick = 0;
  logic togPrev = 1'b0;
  assign externalTriggerInput = trigLevel;
  // Toggle pin only judged while driven; undriven level means nothing
  always @(posedge clock) begin
    cyc <= cyc + 1;
    togPrev <= togglePinOut;
    if (togglePinOe && togglePinOut != togPrev) begin
      toggleGap <= cyc - lastTog;
      lastTog <= cyc;
    end
    if (serialBitTick) begin
      tickGap <= cyc - lastTick;
      lastTick <= cyc;
    end
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the reload timer
`timescale 1ns/1ps
module testbench
  import trb_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  trb_ctrl_type ctrl = '0;
  trb_clr_type flagClr = '0;
  logic [PRE_W-1:0] prescaleValue = '0;
  logic [15:0] reload = '0;
  logic trigLevel = 1'b1;
  wire logic externalTriggerInput, togglePinOut, togglePinOe, overflowFlag, externalFlag;
  wire logic interruptRequest, serialBitTick;
  wire logic [7:0] countHighByte, countLowByte;
  int toggleGap, tickGap;
  int n_mismatch = 0;
  int samples_checked = 0;
  initial forever #12.5 clock = ~clock;
  trb_timer dut_u (.clock, .sys_rst, .ctrl, .flagClr, .prescaleValue,
    .reloadValueHigh(reload[15:8]), .reloadValueLow(reload[7:0]), .externalTriggerInput,
    .togglePinOut, .togglePinOe, .countHighByte, .countLowByte, .overflowFlag,
    .externalFlag, .interruptRequest, .serialBitTick);
  trb_far_end far_u (.clock, .trigLevel, .externalTriggerInput, .togglePinOut,
    .togglePinOe, .serialBitTick, .toggleGap, .tickGap);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Trigger level settles during reset so no stray fall reaches the block
  task automatic do_reset(input logic trig);
    @(posedge clock);
    sys_rst <= 1'b1;
    ctrl <= '0;
    prescaleValue <= '0;
    trigLevel <= trig;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
  endtask
  // Trigger fall while stopped in standard mode loads the count from reload
  task automatic preload();
    ctrl.externalEnable <= 1'b1;
    @(posedge clock);
    trigLevel <= 1'b0;
    @(posedge clock);
    trigLevel <= 1'b1;
  endtask
  task automatic pulse_clr(input logic ovf, input logic ext);
    @(posedge clock);
    flagClr.overflowClr <= ovf;
    flagClr.externalClr <= ext;
    @(posedge clock);
    flagClr <= '0;
    @(negedge clock);
  endtask
  task automatic run_mode(input trb_mode_type m, input logic dn, input logic [15:0] rel,
      input logic [15:0] expCnt, input logic expExt);
    int i;
    logic [15:0] snap;
    do_reset(!dn);
    reload <= rel;
    ctrl.downCountEnable <= dn;
    // Stopped standard up-counter loads its count from the new reload before it starts running
    if (m == MODE_STD && !dn) begin
      preload();
    end else begin
      repeat (2) @(posedge clock);
    end
    ctrl.countModeSelect <= m;
    ctrl.externalEnable <= dn;
    ctrl.runControl <= 1'b1;
    for (i = 0; i < 60 && overflowFlag !== 1'b1; i++) @(negedge clock);
    if (i == 60) begin
      n_mismatch++;
      end_of_test();
    end
    chk("count", expCnt, {countHighByte, countLowByte});
    chk("irq", 1, interruptRequest);
    chk("ext", expExt, externalFlag);
    @(posedge clock);
    ctrl.runControl <= 1'b0;
    repeat (3) @(negedge clock);
    snap = {countHighByte, countLowByte};
    repeat (5) @(negedge clock);
    chk("stopped", snap, {countHighByte, countLowByte});
    pulse_clr(1'b1, 1'b0);
    chk("ovf clr", 0, overflowFlag);
    chk("irq left", m == MODE_STD && !dn, interruptRequest);
  endtask
  task automatic clock_out_baud();
    do_reset(1'b1);
    prescaleValue <= 8'h03;
    reload <= 16'hfffa;
    preload();
    ctrl.externalEnable <= 1'b0;
    ctrl.toggleOutputEnable <= 1'b1;
    ctrl.runControl <= 1'b1;
    repeat (90) @(negedge clock);
    chk("toggle gap", 24, toggleGap);
    chk("oe", 1, togglePinOe);
    pulse_clr(1'b0, 1'b1);
    chk("clock-out irq", 0, interruptRequest);
    do_reset(1'b1);
    reload <= 16'hfffe;
    preload();
    ctrl.transmitClockSelect <= 1'b1;
    ctrl.toggleOutputEnable <= 1'b1;
    ctrl.runControl <= 1'b1;
    repeat (120) @(negedge clock);
    chk("bit gap", 32, tickGap);
    chk("toggle gap", 2, toggleGap);
    chk("ovf", 0, overflowFlag);
    pulse_clr(1'b0, 1'b1);
    chk("baud irq", 0, interruptRequest);
    @(posedge clock);
    trigLevel <= 1'b0;
    repeat (4) @(negedge clock);
    chk("ext", 1, externalFlag);
    chk("ext irq", 1, interruptRequest);
  endtask
  initial begin
    run_mode(MODE_STD, 1'b0, 16'hfffe, 16'hfffe, 1'b1);
    run_mode(MODE_CLR_TOP, 1'b0, 16'h0003, 16'h0000, 1'b0);
    run_mode(MODE_STD, 1'b1, 16'hfff0, 16'hffff, 1'b1);
    run_mode(MODE_CLR_TOP, 1'b1, 16'h0003, 16'h0003, 1'b1);
    run_mode(MODE_DUAL_ONE, 1'b0, 16'h0004, 16'h0000, 1'b0);
    run_mode(MODE_DUAL_TWO, 1'b1, 16'h0004, 16'h0003, 1'b1);
    clock_out_baud();
    end_of_test();
  end
endmodule
bind trb_timer trb_timer_chk chk_u (.clock, .sys_rst, .ctrl, .reloadValueHigh,
  .reloadValueLow, .togglePinOut, .countHighByte, .countLowByte, .overflowFlag,
  .externalFlag, .interruptRequest, .serialBitTick);
